// ===== core/crypto_ctl_pkg.sv
// Purpose: Constants and types for the crypto engine control and key source.
// Assumes: AHB-Lite register access, 32-bit data, one word per register.
// Notes: Rules follow as an untagged list.
// What this block does
// - engine_enable bit 15 enables the engine
// - idle_stop bit 13 halts engine in Idle
// - Idle with idle_stop aborts running operation
// - Rollover event when enabled and counter wraps
// - Done event when enabled; otherwise poll status
// - Input-consumed event when its enable is set
// - op_go starts, hardware clears, software clear stops
// - Low control holds operation, cipher select, mode
// - Mode fields frozen while op_go set
// - Reset zeroes control fields; module disable zeroes all but engine_enable and idle_stop
// - Bits 14 and 9 read as zero
// - kek_only_key1 restricts key 1 to key encryption
// - Locked source from highest set config bit
// - Unlocked: config ignored, software selection used
// - key_source_lock disables software key selection
// - Page lock bits block OTP page programming
// - Soft key disabled and code zero: fail, refuse
// - Code zero selects software key when allowed
package crypto_ctl_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] OFF_CTL_LOW = 8'h00;
	localparam logic [7:0] OFF_CTL_HIGH = 8'h04;
	localparam logic [7:0] OFF_CFG_PAGE = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_OTP_PROG = 8'h10;

	// ==========================================================
	// Field positions
	localparam int CTL_LOW_W = 16;
	localparam int CTL_LOW_WMASK_EN = 15;
	localparam int HIGH_MDIS_BIT = 8;
	localparam int CFG_KEK_BIT = 19;
	localparam int CFG_LKY_LSB = 11;
	localparam int CFG_LOCK_BIT = 10;
	localparam int CFG_WRL_LSB = 1;
	localparam int CFG_SWKD_BIT = 0;
	localparam int OTP_PAGES = 9;

	// ==========================================================
	// Reset values and codes
	localparam logic [15:0] CTL_LOW_RST = 16'h0000;
	localparam logic [31:0] CFG_PAGE_RST = 32'h0000_0000;
	localparam logic [3:0] KEY_SOURCE_SELECT_SOFT = 4'h0;
	localparam logic [31:0] BUS_ZERO = 32'h0000_0000;

	// Low control layout; the two unused bits are kept as zero fields.
	typedef struct packed {
		logic engine_enable;
		logic unused14;
		logic idle_stop;
		logic rollover_irq_enable;
		logic done_irq_enable;
		logic input_free_irq_enable;
		logic unused9;
		logic op_go;
		logic [3:0] operation_select;
		logic cipher_select;
		logic [2:0] cipher_mode;
	} ctl_low_s;

	// Engine events arriving from the datapath.
	typedef struct packed {
		logic op_done;
		logic input_consumed;
		logic counter_rollover;
	} engine_evt_s;

	// Mode fields handed to the datapath with a start.
	typedef struct packed {
		logic [3:0] operation_select;
		logic cipher_select;
		logic [2:0] cipher_mode;
		logic [3:0] key_source;
	} op_cfg_s;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10
	} eng_state_e;

endpackage : crypto_ctl_pkg

// ===== core/crypto_engine_control_key_source_select.sv
// Purpose: Control, key source and OTP lock logic of the crypto engine.
// Assumes: Single AHB-Lite master, whole-word transfers, zero wait states.
// Notes: The datapath outside reports done, consumed and rollover events.
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns
module crypto_engine_control_key_source_select #(
	parameter logic [3:0] KEY1_CODE = 4'h1,
	parameter logic [3:0] KEK_OP_CODE = 4'h3
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// System state
	input wire logic cpu_idle,
	// Datapath events
	input wire crypto_ctl_pkg::engine_evt_s engine_evt,
	// Datapath control
	output logic op_start,
	output logic op_abort,
	output logic engine_busy_flag,
	output crypto_ctl_pkg::op_cfg_s op_cfg,
	output logic kek_only_key1,
	// Event pulses to the system interrupt controller
	output logic rollover_event,
	output logic done_event,
	output logic input_free_event,
	// OTP programming strobe
	output logic otp_prog_pulse,
	output logic [3:0] otp_prog_page
);

	// ==========================================================
	// Bus address phase capture
	logic wr_pend_q;
	logic rd_pend_q;
	logic [7:0] addr_q;
	wire logic bus_take = hsel && hready && htrans[1];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q <= 8'h00;
		end else begin
			wr_pend_q <= bus_take && hwrite;
			rd_pend_q <= bus_take && !hwrite;
			addr_q <= bus_take ? haddr[7:0] : addr_q;
		end
	end

	function automatic logic wr_hit(input logic pend, input logic [7:0] a,
		input logic [7:0] off);
		wr_hit = pend && (a == off);
	endfunction : wr_hit

	wire logic wr_low = wr_hit(wr_pend_q, addr_q, crypto_ctl_pkg::OFF_CTL_LOW);
	wire logic wr_high = wr_hit(wr_pend_q, addr_q,
		crypto_ctl_pkg::OFF_CTL_HIGH);
	wire logic wr_cfg = wr_hit(wr_pend_q, addr_q, crypto_ctl_pkg::OFF_CFG_PAGE);
	wire logic wr_prog = wr_hit(wr_pend_q, addr_q,
		crypto_ctl_pkg::OFF_OTP_PROG);

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// ==========================================================
	// Registers
	crypto_ctl_pkg::ctl_low_s low_q;
	crypto_ctl_pkg::ctl_low_s low_d;
	crypto_ctl_pkg::ctl_low_s wlow;
	logic [3:0] key_source_select_q;
	logic module_disable_control_q;
	logic [31:0] cfg_q;
	logic prog_refused_q;
	crypto_ctl_pkg::eng_state_e state_q;
	crypto_ctl_pkg::eng_state_e state_d;

	assign wlow = hwdata[15:0];

	// Secure configuration fields.
	wire logic key_source_lock = cfg_q[crypto_ctl_pkg::CFG_LOCK_BIT];
	wire logic soft_key_disable = cfg_q[crypto_ctl_pkg::CFG_SWKD_BIT];
	wire logic [7:0] locked_key_source_cfg =
		cfg_q[crypto_ctl_pkg::CFG_LKY_LSB +: 8];
	wire logic [8:0] otp_page_write_lock =
		cfg_q[crypto_ctl_pkg::CFG_WRL_LSB +: crypto_ctl_pkg::OTP_PAGES];
	assign kek_only_key1 = cfg_q[crypto_ctl_pkg::CFG_KEK_BIT];

	// Highest set bit picks the code; bit 7 jumps to the top code.
	function automatic logic [3:0] locked_code(input logic [7:0] cfg);
		locked_code = 4'h0;
		for (int i = 0; i < 7; i++) begin
			if (cfg[i]) begin
				locked_code = 4'(i + 1);
			end
		end
		if (cfg[7]) begin
			locked_code = 4'hF;
		end
	endfunction : locked_code

	wire logic [3:0] eff_key_source = key_source_lock ?
		locked_code(locked_key_source_cfg) :
		key_source_select_q;

	// Code zero is the software key; it fails only when disabled.
	wire logic key_failure_flag = soft_key_disable &&
		(eff_key_source == crypto_ctl_pkg::KEY_SOURCE_SELECT_SOFT);
	wire logic key1_denied = kek_only_key1 &&
		(eff_key_source == KEY1_CODE) &&
		(low_q.operation_select != KEK_OP_CODE);

	// ==========================================================
	// Operation sequencing
	wire logic idle_halt = cpu_idle && low_q.idle_stop;
	// A disable write acts in its own cycle so a read right after sees it.
	wire logic mdis_now = module_disable_control_q ||
		(wr_high && hwdata[crypto_ctl_pkg::HIGH_MDIS_BIT]);
	wire logic can_start = low_q.engine_enable && !idle_halt &&
		!key_failure_flag && !key1_denied && !mdis_now;
	wire logic refuse = low_q.op_go && (key_failure_flag || key1_denied);
	wire logic sw_stop = wr_low && !wlow.op_go;
	wire logic run_end = state_q == crypto_ctl_pkg::ST_RUN &&
		(engine_evt.op_done || sw_stop || idle_halt ||
		mdis_now);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			crypto_ctl_pkg::ST_IDLE: begin
				if (low_q.op_go && can_start && !sw_stop) begin
					state_d = crypto_ctl_pkg::ST_RUN;
				end
			end
			crypto_ctl_pkg::ST_RUN: begin
				if (run_end) begin
					state_d = crypto_ctl_pkg::ST_IDLE;
				end
			end
		endcase
	end

	assign op_start = state_q == crypto_ctl_pkg::ST_IDLE &&
		state_d == crypto_ctl_pkg::ST_RUN;
	assign op_abort = run_end && !engine_evt.op_done;
	assign engine_busy_flag = state_q == crypto_ctl_pkg::ST_RUN;

	// Low control next value: frozen mode fields, zeroed on disable except engine_enable and idle_stop.
	always_comb begin
		low_d = low_q;
		if (wr_low) begin
			low_d.engine_enable = wlow.engine_enable;
			low_d.idle_stop = wlow.idle_stop;
			low_d.rollover_irq_enable = wlow.rollover_irq_enable;
			low_d.done_irq_enable = wlow.done_irq_enable;
			low_d.input_free_irq_enable = wlow.input_free_irq_enable;
			low_d.op_go = wlow.op_go;
			if (!low_q.op_go) begin
				low_d.operation_select = wlow.operation_select;
				low_d.cipher_select = wlow.cipher_select;
				low_d.cipher_mode = wlow.cipher_mode;
			end
		end
		if (state_q == crypto_ctl_pkg::ST_RUN && run_end) begin
			low_d.op_go = 1'b0;
		end
		if (refuse) begin
			low_d.op_go = 1'b0;
		end
		low_d.unused14 = 1'b0;
		low_d.unused9 = 1'b0;
		if (mdis_now) begin
			low_d.rollover_irq_enable = 1'b0;
			low_d.done_irq_enable = 1'b0;
			low_d.input_free_irq_enable = 1'b0;
			low_d.op_go = 1'b0;
			low_d.operation_select = 4'h0;
			low_d.cipher_select = 1'b0;
			low_d.cipher_mode = 3'h0;
		end
	end

	// ==========================================================
	// OTP page programming gate
	wire logic [3:0] prog_page = hwdata[3:0];
	wire logic page_ok = (prog_page < 4'(crypto_ctl_pkg::OTP_PAGES)) &&
		!otp_page_write_lock[prog_page];
	wire logic cfg_ok = !otp_page_write_lock[0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			low_q <= crypto_ctl_pkg::CTL_LOW_RST;
			key_source_select_q <= 4'h0;
			module_disable_control_q <= 1'b0;
			cfg_q <= crypto_ctl_pkg::CFG_PAGE_RST;
			state_q <= crypto_ctl_pkg::ST_IDLE;
			prog_refused_q <= 1'b0;
			otp_prog_pulse <= 1'b0;
			otp_prog_page <= 4'h0;
		end else begin
			low_q <= low_d;
			state_q <= state_d;
			if (wr_high && !key_source_lock) begin
				key_source_select_q <= hwdata[3:0];
			end
			if (wr_high) begin
				module_disable_control_q <= hwdata[crypto_ctl_pkg::HIGH_MDIS_BIT];
			end
			if (wr_cfg && cfg_ok) begin
				cfg_q <= cfg_q | hwdata; // One-time bits only ever set.
			end
			otp_prog_pulse <= wr_prog && page_ok;
			otp_prog_page <= wr_prog ? prog_page : otp_prog_page;
			if (wr_prog) begin
				prog_refused_q <= !page_ok;
			end
		end
	end

	// ==========================================================
	// Events, silenced while the engine is off
	wire logic ev_on = low_q.engine_enable;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rollover_event <= 1'b0;
			done_event <= 1'b0;
			input_free_event <= 1'b0;
		end else begin
			rollover_event <= ev_on && low_q.rollover_irq_enable &&
				engine_evt.counter_rollover;
			done_event <= ev_on && low_q.done_irq_enable &&
				engine_busy_flag && engine_evt.op_done;
			input_free_event <= ev_on && low_q.input_free_irq_enable &&
				engine_busy_flag && engine_evt.input_consumed;
		end
	end

	assign op_cfg = {low_q.operation_select, low_q.cipher_select,
		low_q.cipher_mode, eff_key_source};

	// ==========================================================
	// Read data
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = crypto_ctl_pkg::BUS_ZERO;
		unique case (haddr[7:0])
			crypto_ctl_pkg::OFF_CTL_LOW: rd_mux = {16'h0000, low_q};
			crypto_ctl_pkg::OFF_CTL_HIGH: rd_mux = {23'h00_0000,
				module_disable_control_q, 4'h0, key_source_select_q};
			crypto_ctl_pkg::OFF_CFG_PAGE: rd_mux = cfg_q;
			crypto_ctl_pkg::OFF_STATUS: rd_mux = {24'h00_0000,
				eff_key_source, prog_refused_q, key1_denied,
				key_failure_flag, engine_busy_flag};
			default: rd_mux = crypto_ctl_pkg::BUS_ZERO;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= crypto_ctl_pkg::BUS_ZERO;
		end else if (bus_take && !hwrite) begin
			hrdata <= rd_mux;
		end
	end

endmodule : crypto_engine_control_key_source_select

// ===== dv/crypto_ctl_checker_assertions.sv
// Purpose: Concurrent checks on the crypto control block ports.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: Bound to every instance of the control block.
`timescale 1ns/1ns
module crypto_ctl_checker (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Watched signals
	input wire crypto_ctl_pkg::engine_evt_s engine_evt,
	input wire logic op_start,
	input wire logic op_abort,
	input wire logic engine_busy_flag,
	input wire logic rollover_event,
	input wire logic done_event,
	input wire logic input_free_event,
	input wire logic otp_prog_pulse,
	input wire logic [3:0] otp_prog_page
);
	// ==========================================================
	// Sequences
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_launch;
		!engine_busy_flag ##1 engine_busy_flag;
	endsequence
	sequence s_finish;
		engine_busy_flag && engine_evt.op_done && !op_abort;
	endsequence
	// ==========================================================
	// Properties
	property p_start;
		op_start |-> s_launch;
	endproperty
	a_start: assert property (p_start) else $error("start not taken");
	property p_finish;
		s_finish |=> !engine_busy_flag;
	endproperty
	a_finish: assert property (p_finish) else $error("busy after done");
	property p_done_pulse;
		s_finish ##1 done_event |=> !done_event;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("long done");
	property p_done_cause;
		done_event |-> $past(engine_evt.op_done && engine_busy_flag);
	endproperty
	a_done_cause: assert property (p_done_cause) else $error("stray done");
	property p_roll;
		rollover_event |-> $past(engine_evt.counter_rollover);
	endproperty
	a_roll: assert property (p_roll) else $error("stray rollover");
	property p_free;
		input_free_event |-> $past(engine_evt.input_consumed && engine_busy_flag);
	endproperty
	a_free: assert property (p_free) else $error("stray input free");
	property p_abort;
		op_abort |=> !engine_busy_flag;
	endproperty
	a_abort: assert property (p_abort) else $error("busy after abort");
	property p_page;
		otp_prog_pulse |-> otp_prog_page < 4'h9;
	endproperty
	a_page: assert property (p_page) else $error("bad page programmed");
endmodule : crypto_ctl_checker

bind crypto_engine_control_key_source_select crypto_ctl_checker u_chk (.hclk(hclk),
	.hresetn(hresetn), .engine_evt(engine_evt), .op_start(op_start),
	.op_abort(op_abort), .engine_busy_flag(engine_busy_flag),
	.rollover_event(rollover_event), .done_event(done_event),
	.input_free_event(input_free_event), .otp_prog_pulse(otp_prog_pulse),
	.otp_prog_page(otp_prog_page));

// ===== dv/tb.sv
// Purpose: Self-checking bench for the crypto control block.
// Assumes: Zero-wait AHB-Lite slave, whole-word transfers.
// Notes: The bench stands in for the datapath events.
`timescale 1ns/1ns
module tb;
	localparam logic [7:0] LO = crypto_ctl_pkg::OFF_CTL_LOW;
	localparam logic [7:0] HI = crypto_ctl_pkg::OFF_CTL_HIGH;
	localparam logic [7:0] CF = crypto_ctl_pkg::OFF_CFG_PAGE;
	localparam logic [7:0] ST = crypto_ctl_pkg::OFF_STATUS;
	localparam logic [7:0] OT = crypto_ctl_pkg::OFF_OTP_PROG;
	logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, cpu_idle = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, v;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, op_start, op_abort, engine_busy_flag;
	logic kek_only_key1, rollover_event, done_event, input_free_event;
	logic otp_prog_pulse;
	logic [3:0] otp_prog_page, pg;
	wire logic hready;
	crypto_ctl_pkg::engine_evt_s engine_evt = '0;
	crypto_ctl_pkg::op_cfg_s op_cfg;
	int miscompares = 0, samples_checked = 0, np = 0, n_start = 0;
	int n_abort = 0;
	assign hready = hreadyout;
	crypto_engine_control_key_source_select dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .cpu_idle(cpu_idle),
		.engine_evt(engine_evt), .op_start(op_start), .op_abort(op_abort),
		.engine_busy_flag(engine_busy_flag), .op_cfg(op_cfg),
		.kek_only_key1(kek_only_key1), .rollover_event(rollover_event),
		.done_event(done_event), .input_free_event(input_free_event),
		.otp_prog_pulse(otp_prog_pulse), .otp_prog_page(otp_prog_page));
	always #10 hclk = ~hclk;
	always @(posedge hclk) begin
		if (otp_prog_pulse === 1'b1) begin
			np++;
			pg <= otp_prog_page;
		end
		if (op_start === 1'b1) begin
			n_start++;
		end
		if (op_abort === 1'b1) begin
			n_abort++;
		end
	end
	// ==========================================================
	// Bus and checking tasks
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
			miscompares++;
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask : cyc
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		v = hrdata;
		#1;
	endtask : xfer
	task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		xfer(1'b0, a, 32'h0000_0000);
		chk(v & m, e);
	endtask : rdchk
	task automatic ev(input logic [2:0] x);
		engine_evt <= x;
		cyc(1);
		engine_evt <= '0;
	endtask : ev
	// ==========================================================
	// Scenarios
	task automatic t_fields;
		rdchk(LO, 32'hFFFF_FFFF, 32'h0000_0000);
		rdchk(8'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
		xfer(1'b1, LO, 32'h0000_FEFF);
		rdchk(LO, 32'hFFFF_FFFF, 32'h0000_BCFF);
		chk(32'(op_cfg[11:4]), 32'h0000_00FF);
		xfer(1'b1, LO, 32'h0000_0000);
	endtask : t_fields
	task automatic t_run;
		xfer(1'b1, HI, 32'h0000_0002);
		xfer(1'b1, LO, 32'h0000_8D12);
		cyc(1);
		chk(32'(engine_busy_flag), 32'h0000_0001);
		chk(32'(n_start), 32'h0000_0001);
		chk(32'(op_cfg), 32'h0000_0122);
		xfer(1'b1, LO, 32'h0000_8D34);
		rdchk(LO, 32'h0000_00FF, 32'h0000_0012);
		ev(3'h2);
		chk(32'(input_free_event), 32'h0000_0001);
		ev(3'h4);
		chk(32'(done_event), 32'h0000_0001);
		rdchk(LO, 32'h0000_0100, 32'h0000_0000);
		xfer(1'b1, LO, 32'h0000_8112);
		cyc(1);
		xfer(1'b1, LO, 32'h0000_8012);
		cyc(1);
		chk(32'(engine_busy_flag), 32'h0000_0000);
		chk(32'(n_abort), 32'h0000_0001);
	endtask : t_run
	task automatic t_idle;
		cpu_idle <= 1'b1;
		xfer(1'b1, LO, 32'h0000_A112);
		cyc(3);
		chk(32'(engine_busy_flag), 32'h0000_0000);
		cpu_idle <= 1'b0;
		cyc(2);
		chk(32'(engine_busy_flag), 32'h0000_0001);
		cpu_idle <= 1'b1;
		cyc(2);
		chk(32'(engine_busy_flag), 32'h0000_0000);
		chk(32'(n_abort), 32'h0000_0002);
		xfer(1'b1, LO, 32'h0000_0000);
		cpu_idle <= 1'b0;
	endtask : t_idle
	task automatic t_disable;
		xfer(1'b1, LO, 32'h0000_1100);
		cyc(3);
		chk(32'(engine_busy_flag), 32'h0000_0000);
		chk(32'(n_start), 32'h0000_0003);
		ev(3'h1);
		chk(32'(rollover_event), 32'h0000_0000);
		xfer(1'b1, LO, 32'h0000_9000);
		ev(3'h1);
		chk(32'(rollover_event), 32'h0000_0001);
		xfer(1'b1, HI, 32'h0000_0102);
		rdchk(LO, 32'hFFFF_FFFF, 32'h0000_8000);
	endtask : t_disable
	task automatic t_key;
		logic [31:0] cw[4] = '{32'h0000_0800, 32'h0000_0400, 32'h0000_2000,
			32'h0004_0000};
		logic [31:0] cs[4] = '{32'h0000_0020, 32'h0000_0010, 32'h0000_0030,
			32'h0000_00F0};
		logic [31:0] cd[4] = '{32'h0000_0000, 32'h0000_0004, 32'h0000_0000,
			32'h0000_0000};
		xfer(1'b1, HI, 32'h0000_0000);
		rdchk(ST, 32'h0000_00F2, 32'h0000_0000);
		xfer(1'b1, CF, 32'h0000_0001);
		rdchk(ST, 32'h0000_0002, 32'h0000_0002);
		xfer(1'b1, LO, 32'h0000_8100);
		cyc(2);
		chk(32'(engine_busy_flag), 32'h0000_0000);
		xfer(1'b1, HI, 32'h0000_0002);
		rdchk(ST, 32'h0000_0002, 32'h0000_0000);
		xfer(1'b1, CF, 32'h0008_0000);
		chk(32'(kek_only_key1), 32'h0000_0001);
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, CF, cw[i]);
			rdchk(ST, 32'h0000_00F0, cs[i]);
			rdchk(ST, 32'h0000_0004, cd[i]);
		end
		xfer(1'b1, HI, 32'h0000_0005);
		rdchk(ST, 32'h0000_00F0, 32'h0000_00F0);
	endtask : t_key
	task automatic t_otp;
		cpu_idle <= 1'b0;
		xfer(1'b1, CF, 32'h0000_0010);
		xfer(1'b1, OT, 32'h0000_0003);
		cyc(2);
		chk(32'(np), 32'h0000_0000);
		rdchk(ST, 32'h0000_0008, 32'h0000_0008);
		xfer(1'b1, OT, 32'h0000_0002);
		cyc(2);
		chk(32'(np), 32'h0000_0001);
		chk(32'(pg), 32'h0000_0002);
		xfer(1'b1, OT, 32'h0000_0009);
		cyc(2);
		chk(32'(np), 32'h0000_0001);
		xfer(1'b1, CF, 32'h0000_0002);
		xfer(1'b1, CF, 32'h0010_0000);
		rdchk(CF, 32'h0010_0002, 32'h0000_0002);
	endtask : t_otp
	task automatic t_reset;
		xfer(1'b1, LO, 32'h0000_9C35);
		hresetn <= 1'b0;
		cyc(2);
		hresetn <= 1'b1;
		chk(32'(op_cfg), 32'h0000_0000);
		rdchk(LO, 32'hFFFF_FFFF, 32'h0000_0000);
	endtask : t_reset
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim
	initial begin
		#100000;
		miscompares++;
		end_sim();
	end
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		#1;
		t_fields();
		t_run();
		t_idle();
		t_disable();
		t_key();
		t_otp();
		t_reset();
		end_sim();
	end
endmodule : tb
